/* File: tmrc_pkg.sv */
// Shared constants for the timer run and cascade control block
package tmrc_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] TMRC_CTRL_OFS = 8'h00;
   localparam logic [7:0] TMRC_MODE_OFS = 8'h04;
   localparam logic [7:0] TMRC_T1_OFS = 8'h08;
   localparam logic [7:0] TMRC_T2_OFS = 8'h0c;
   localparam logic [7:0] TMRC_T3_OFS = 8'h10;
   localparam logic [7:0] TMRC_PAIR_OFS = 8'h14;
   // ==========================================================
   // Field positions and control field width
   localparam int TMRC_CTRL_W = 4;
   localparam int TMRC_RUN1_BIT = 0;
   localparam int TMRC_RUN2_BIT = 1;
   localparam int TMRC_RUN3_BIT = 2;
   localparam int TMRC_CASC_BIT = 3;
   localparam int TMRC_CAPSEL_BIT = 0;
   // ==========================================================
   // Reset values and count constants
   localparam logic [3:0] TMRC_CTRL_RST = 4'h0;
   localparam logic TMRC_CAPSEL_RST = 1'b0;
   localparam logic [7:0] TMRC_CNT8_RST = 8'h00;
   localparam logic [7:0] TMRC_CNT8_MAX = 8'hff;
   localparam logic [7:0] TMRC_CNT8_ONE = 8'h01;
   localparam logic [15:0] TMRC_CNT16_RST = 16'h0000;
   localparam logic [15:0] TMRC_CNT16_ONE = 16'h0001;
   localparam logic [15:0] TMRC_PAIR_RST = 16'hffff;
   localparam logic [31:0] TMRC_RDATA_RST = 32'h0000_0000;
endpackage

/* File: tmrc_top.sv */
// Run, cascade and timer 3 mode control with an APB register slave
// Notes on behaviour
// R1: Timer 2 run bit gates timer 2 increments; clear means hold.
// R2: Writing 1 to timer 2 run starts it, 0 stops it.
// R3: Cascade bit 3 of control joins timers into 16 bits, timer 2 high.
// R4: Software keeps timer 2 run set in cascade, else upper byte holds.
// R5: In cascade, setting timer 1 run starts the combined counter.
// R6: In cascade, clearing timer 1 run stops the combined counter.
// R7: Without cascade, timer 1 run starts timer 1 as its own 8 bits.
// R8: Timer 3 run bit starts timer 3 when set, stops when clear.
// R9: Select 1: pair captures timer 3; timer 3 runs without period.
// R10: Select 0: pair is the period register of timer 3.
// R11: A stopped timer keeps its count and resumes from it.
`timescale 1ns/1ps
`default_nettype none
module tmrc_top
   import tmrc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic count_tick,
   input wire logic capture_pin
);
   // ==========================================================
   // Register state
   logic [TMRC_CTRL_W-1:0] ctrl_q, ctrl_d;
   logic capsel_q, capsel_d;
   logic [7:0] t1_q, t1_d, t2_q, t2_d;
   logic [15:0] t3_q, t3_d, pair_q, pair_d;
   logic [31:0] prdata_q, prdata_d;
   logic cap_s1_q, cap_s2_q, cap_s3_q;
   logic hit, acc, wr;
   logic wr_ctrl, wr_mode, wr_t1, wr_t2, wr_t3, wr_pair;
   logic run1, run2, run3, casc, cap_edge, t1_inc, t2_inc, t3_inc;
   logic t3_wrap;
   logic [31:0] rdata;

   assign run1 = ctrl_q[TMRC_RUN1_BIT];
   assign run2 = ctrl_q[TMRC_RUN2_BIT];
   assign run3 = ctrl_q[TMRC_RUN3_BIT];
   assign casc = ctrl_q[TMRC_CASC_BIT];
   // First stage is read only by the second
   assign cap_edge = cap_s2_q & ~cap_s3_q;

   // ==========================================================
   // APB decode
   always_comb begin
      hit = 1'b1;
      rdata = TMRC_RDATA_RST;
      if (paddr == TMRC_CTRL_OFS) begin
         rdata = {{(32-TMRC_CTRL_W){1'b0}}, ctrl_q};
      end else if (paddr == TMRC_MODE_OFS) begin
         rdata = {31'h0000_0000, capsel_q};
      end else if (paddr == TMRC_T1_OFS) begin
         rdata = {24'h00_0000, t1_q};
      end else if (paddr == TMRC_T2_OFS) begin
         rdata = {24'h00_0000, t2_q};
      end else if (paddr == TMRC_T3_OFS) begin
         rdata = {16'h0000, t3_q};
      end else if (paddr == TMRC_PAIR_OFS) begin
         rdata = {16'h0000, pair_q};
      end else begin
         hit = 1'b0;
      end
   end

   // Zero wait states; read data is captured in the setup cycle
   assign acc = psel & penable;
   assign pready = 1'b1;
   assign pslverr = acc & ~hit;
   assign prdata = prdata_q;
   assign wr = acc & pwrite & hit;
   assign wr_ctrl = wr & (paddr == TMRC_CTRL_OFS);
   assign wr_mode = wr & (paddr == TMRC_MODE_OFS);
   assign wr_t1 = wr & (paddr == TMRC_T1_OFS);
   assign wr_t2 = wr & (paddr == TMRC_T2_OFS);
   assign wr_t3 = wr & (paddr == TMRC_T3_OFS);
   assign wr_pair = wr & (paddr == TMRC_PAIR_OFS);

   // ==========================================================
   // Timer next state
   always_comb begin
      ctrl_d = ctrl_q;
      capsel_d = capsel_q;
      t1_d = t1_q;
      t2_d = t2_q;
      t3_d = t3_q;
      pair_d = pair_q;
      prdata_d = prdata_q;
      if (psel & ~penable) begin
         prdata_d = rdata;
      end
      if (wr_ctrl) begin
         ctrl_d = pwdata[TMRC_CTRL_W-1:0]; // R2 R8
      end
      if (wr_mode) begin
         capsel_d = pwdata[TMRC_CAPSEL_BIT];
      end
      t1_inc = count_tick & run1; // R5 R6 R7
      // Upper byte needs both run bits in cascade
      if (casc) begin
         t2_inc = t1_inc & run2 & (t1_q == TMRC_CNT8_MAX); // R3 R4
      end else begin
         t2_inc = count_tick & run2; // R1 R7
      end
      t3_inc = count_tick & run3; // R8
      t3_wrap = ~capsel_q & (t3_q == pair_q); // R9 R10
      // Stopped counters simply keep their value
      if (wr_t1) begin
         t1_d = pwdata[7:0];
      end else if (t1_inc) begin
         t1_d = t1_q + TMRC_CNT8_ONE; // R11
      end
      if (wr_t2) begin
         t2_d = pwdata[7:0];
      end else if (t2_inc) begin
         t2_d = t2_q + TMRC_CNT8_ONE; // R1 R11
      end
      if (wr_t3) begin
         t3_d = pwdata[15:0];
      end else if (t3_inc & t3_wrap) begin
         t3_d = TMRC_CNT16_RST; // R10
      end else if (t3_inc) begin
         t3_d = t3_q + TMRC_CNT16_ONE; // R8 R11
      end
      // Capture beats a software write to the pair
      if (capsel_q & cap_edge) begin
         pair_d = t3_q; // R9
      end else if (wr_pair & ~capsel_q) begin
         pair_d = pwdata[15:0]; // R10
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= TMRC_CTRL_RST;
         capsel_q <= TMRC_CAPSEL_RST;
         t1_q <= TMRC_CNT8_RST;
         t2_q <= TMRC_CNT8_RST;
         t3_q <= TMRC_CNT16_RST;
         pair_q <= TMRC_PAIR_RST;
         prdata_q <= TMRC_RDATA_RST;
      end else begin
         ctrl_q <= ctrl_d;
         capsel_q <= capsel_d;
         t1_q <= t1_d;
         t2_q <= t2_d;
         t3_q <= t3_d;
         pair_q <= pair_d;
         prdata_q <= prdata_d;
      end
   end

   // ==========================================================
   // Capture pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_s1_q <= 1'b0;
         cap_s2_q <= 1'b0;
         cap_s3_q <= 1'b0;
      end else begin
         cap_s1_q <= capture_pin;
         cap_s2_q <= cap_s1_q;
         cap_s3_q <= cap_s2_q;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   t2_hold_a: assert property ( // R1 R11
      (!run2 && !wr_t2) |=> $stable(t2_q))
      else $error("timer 2 moved while stopped");
   t2_count_a: assert property ( // R2
      (run2 && !casc && count_tick && !wr_t2)
      |=> t2_q == $past(t2_q) + TMRC_CNT8_ONE)
      else $error("timer 2 did not count");
   casc_carry_a: assert property ( // R3 R5
      (casc && run1 && run2 && count_tick && t1_q == TMRC_CNT8_MAX
       && !wr_t1 && !wr_t2)
      |=> (t1_q == TMRC_CNT8_RST && t2_q == $past(t2_q) + TMRC_CNT8_ONE))
      else $error("cascade carry lost");
   casc_upper_a: assert property ( // R6
      (casc && !run1 && !wr_t2) |=> $stable(t2_q))
      else $error("upper byte moved with low half stopped");
   casc_stop_a: assert property ( // R6
      (casc && !run1 && !wr_t1 && !wr_t2) [*2] |=> $stable({t2_q, t1_q}))
      else $error("combined counter moved while stopped");
   t1_indep_a: assert property ( // R7
      (!casc && !run2 && run1 && count_tick && !wr_t1 && !wr_t2
       && t1_q == TMRC_CNT8_MAX)
      |=> (t1_q == TMRC_CNT8_RST && $stable(t2_q)))
      else $error("independent timer 1 carried into timer 2");
   t3_run_a: assert property ( // R8 R11
      (!wr_t3 && !(count_tick && run3)) |=> $stable(t3_q))
      else $error("timer 3 moved while stopped");
   cap_load_a: assert property ( // R9
      (capsel_q && cap_edge) |=> pair_q == $past(t3_q))
      else $error("capture value wrong");
   cap_free_a: assert property ( // R9
      (capsel_q && run3 && count_tick && !wr_t3)
      |=> t3_q == $past(t3_q) + TMRC_CNT16_ONE)
      else $error("timer 3 wrapped in capture mode");
   period_wrap_a: assert property ( // R10
      (!capsel_q && run3 && count_tick && !wr_t3 && t3_q == pair_q)
      |=> t3_q == TMRC_CNT16_RST)
      else $error("timer 3 missed its period");
   ctrl_wr_a: assert property ( // R2 R8
      wr_ctrl |=> ctrl_q == $past(pwdata[TMRC_CTRL_W-1:0]))
      else $error("control write not taken");

   casc_wrap_c: cover property (casc && t2_inc && t2_q == TMRC_CNT8_MAX);
   cap_c: cover property (capsel_q && cap_edge && run3);
   period_c: cover property (!capsel_q && t3_inc && t3_wrap);
   resume_c: cover property (!run1 ##1 run1 && t1_inc);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the timer run and cascade control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tmrc_pkg::*;
   // ==========================================================
   // Signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic count_tick = 1'b0;
   logic capture_pin = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r, x;
   logic pready, pslverr, e;
   logic [7:0] a1, a2;
   logic [15:0] v;
   int err_count = 0;
   int n_tests = 0;
   int seed = 36032;
   int n, p;
   always #12.5 pclk = ~pclk;
   tmrc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_tick(count_tick), .capture_pin(capture_pin));
   // ==========================================================
   // Tasks and helper functions
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Waits are bounded so a dead slave ends the run
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 50) begin
         err_count++;
         $display("mismatch %0t bus hang", $time);
         print_verdict();
      end
      // Idle edge so the next setup never re-drives psel in this step
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk({31'h0, e}, 32'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask
   task tk(input int k);
      count_tick <= 1'b1;
      repeat (k) @(posedge pclk);
      count_tick <= 1'b0;
      @(posedge pclk);
   endtask
   function logic [31:0] per(input int k, input int q);
      return 32'(k % (q + 1));
   endfunction
   function int rnd(input int m);
      return 1 + int'($unsigned($random(seed)) % m);
   endfunction
   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(TMRC_CTRL_OFS, 32'h0);
      rd(TMRC_MODE_OFS, 32'h0);
      rd(TMRC_T3_OFS, 32'h0);
      rd(TMRC_PAIR_OFS, 32'hffff);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      $display("test reset done");
      n = rnd(7);
      wr(TMRC_CTRL_OFS, 32'h1);
      tk(n);
      rd(TMRC_T1_OFS, 32'(n));
      rd(TMRC_T2_OFS, 32'h0);
      wr(TMRC_CTRL_OFS, 32'h2);
      tk(3);
      rd(TMRC_T2_OFS, 32'h3);
      rd(TMRC_T1_OFS, 32'(n));
      wr(TMRC_CTRL_OFS, 32'h0);
      tk(2);
      rd(TMRC_T2_OFS, 32'h3);
      wr(TMRC_CTRL_OFS, 32'h2);
      tk(1);
      rd(TMRC_T2_OFS, 32'h4);
      // Independent timer 1 wraps without touching timer 2
      wr(TMRC_T1_OFS, 32'hff);
      wr(TMRC_CTRL_OFS, 32'h1);
      tk(1);
      rd(TMRC_T1_OFS, 32'h0);
      rd(TMRC_T2_OFS, 32'h4);
      $display("test eight-bit done");
      a1 = 8'hf8 + 8'($unsigned($random(seed)) % 8);
      a2 = 8'($random(seed));
      // At least nine ticks so the low byte always carries
      n = 8 + rnd(7);
      v = {a2, a1} + 16'(n);
      wr(TMRC_T1_OFS, {24'h0, a1});
      wr(TMRC_T2_OFS, {24'h0, a2});
      wr(TMRC_CTRL_OFS, 32'hb);
      tk(n);
      rd(TMRC_T1_OFS, {24'h0, v[7:0]});
      rd(TMRC_T2_OFS, {24'h0, v[15:8]});
      wr(TMRC_CTRL_OFS, 32'ha);
      tk(4);
      rd(TMRC_T1_OFS, {24'h0, v[7:0]});
      rd(TMRC_T2_OFS, {24'h0, v[15:8]});
      wr(TMRC_T1_OFS, 32'hff);
      wr(TMRC_T2_OFS, 32'h10);
      wr(TMRC_CTRL_OFS, 32'h9);
      tk(1);
      rd(TMRC_T1_OFS, 32'h0);
      rd(TMRC_T2_OFS, 32'h10);
      $display("test cascade done");
      p = 1 + rnd(4);
      // More ticks than the longest period, so a wrap always happens
      n = 6 + rnd(6);
      wr(TMRC_PAIR_OFS, 32'(p));
      wr(TMRC_CTRL_OFS, 32'h4);
      tk(n);
      rd(TMRC_T3_OFS, per(n, p));
      wr(TMRC_CTRL_OFS, 32'h0);
      tk(2);
      rd(TMRC_T3_OFS, per(n, p));
      // Capture mode has no period, so the count passes the old pair
      x = per(n, p) + 32'(p) + 32'h1;
      wr(TMRC_MODE_OFS, 32'h1);
      wr(TMRC_CTRL_OFS, 32'h4);
      tk(p + 1);
      rd(TMRC_T3_OFS, x);
      wr(TMRC_CTRL_OFS, 32'h0);
      capture_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      capture_pin <= 1'b0;
      rd(TMRC_PAIR_OFS, x);
      wr(TMRC_PAIR_OFS, 32'h3);
      rd(TMRC_PAIR_OFS, x);
      $display("test timer three done");
      print_verdict();
   end
endmodule
`default_nettype wire
